// >>> pkg/port_two_defines.svh
// Purpose: Offsets, field positions, reset values and bus timing of the port two block
// Assumes: Register indices are the upper 16 bits of the 18-bit address; byte address = index * 4
// Notes:   Definitions only
`ifndef PORT_TWO_DEFINES_SVH
`define PORT_TWO_DEFINES_SVH

`define PORT_WIDTH         8
`define AVS_ADDR_W         18
`define AVS_DATA_W         32

// Register indices, each one aligned 32-bit word on the bus
`define DIR_IDX            16'hfeb1
`define PIN_LEVELS_IDX     16'hff51
`define OUT_LATCH_IDX      16'hff61
`define IDX_LSB            2

`define DIR_RESET          8'h00
`define OUT_LATCH_RESET    8'h00
`define LEVELS_RESET       8'h00
// Value returned by a read of the write-only direction register
`define DIR_READ_VALUE     8'hff
`define UNMAPPED_READ      32'h0000_0000

// Byte lane that carries the 8-bit register data
`define DATA_LANE          0
// Cycles from a request to waitrequest low
`define BUS_ANSWER_CYCLES  1

`endif

// >>> pkg/port_two_pkg.sv
// Purpose: Types shared by the port two block
// Assumes: Constants live in port_two_defines.svh
// Notes:   Types only
package port_two_pkg;

   typedef logic [7:0] port_byte_t;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage

// >>> pkg/pin_select_if.sv
// Purpose: Carries the per-pin driver selection between control and pin mux
// Assumes: One clock domain, all signals combinational between the two modules
// Notes:   ctrl drives the sources, mux returns the chosen drive
`timescale 1ns/1ns
interface pin_select_if;
   import port_two_pkg::*;

   port_byte_t dir;
   port_byte_t latch;
   port_byte_t tmr_sel_nz;
   port_byte_t tmr_out;
   port_byte_t tpu_oe;
   port_byte_t tpu_out;
   port_byte_t ppg_en;
   port_byte_t ppg_out;
   logic       hold_alt;
   port_byte_t drv_out;
   port_byte_t drv_oe;

   modport ctrl (
      output dir, latch, tmr_sel_nz, tmr_out, tpu_oe, tpu_out, ppg_en, ppg_out, hold_alt,
      input  drv_out, drv_oe
   );

   modport mux (
      input  dir, latch, tmr_sel_nz, tmr_out, tpu_oe, tpu_out, ppg_en, ppg_out, hold_alt,
      output drv_out, drv_oe
   );

endinterface

// >>> rtl/port_two_pin_mux.sv
// Purpose: Chooses, pin by pin, which unit drives the pin and whether it is driven
// Assumes: All selects come from the same clock domain
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/1ns
`include "port_two_defines.svh"
module port_two_pin_mux (
   pin_select_if.mux sel
);
   import port_two_pkg::*;

   port_byte_t out_v;
   port_byte_t oe_v;

   for (genvar g = 0; g < `PORT_WIDTH; g++) begin : g_pin
      // Precedence: 8-bit timer, timer unit, then port or pulse output
      assign out_v[g] = (!sel.hold_alt && sel.tmr_sel_nz[g]) ? sel.tmr_out[g] :
                        (!sel.hold_alt && sel.tpu_oe[g])     ? sel.tpu_out[g] :
                        (!sel.hold_alt && sel.ppg_en[g])     ? sel.ppg_out[g] :
                                                               sel.latch[g];
      assign oe_v[g]  = (!sel.hold_alt && (sel.tmr_sel_nz[g] || sel.tpu_oe[g])) ? 1'b1 :
                                                               sel.dir[g];
   end

   assign sel.drv_out = out_v;
   assign sel.drv_oe  = oe_v;

endmodule

// >>> rtl/port_two_top.sv
// Purpose: Eight-bit general purpose port with direction, output latch and pin levels
// Assumes: Avalon-MM slave with waitrequest, byte addresses, data in byte lane 0
// Notes:   i_rst_n is the power-on reset; hardware standby arrives on a pin
//
// Functional notes
// - The direction register is eight bits, write-only, and reads give a fixed filler.
// - A direction bit of 1 makes its pin an output and 0 makes it an input.
// - Power-on reset and hardware standby clear direction and output latch to zero.
// - Manual reset and software standby keep direction and output latch.
// - The output latch is an eight-bit read and write register holding pin output data.
// - The pin-state register is read-only and writes to it change nothing.
// - Pin-state reads give the latch bit where the direction bit is 1.
// - Pin-state reads give the sampled pin level where the direction bit is 0.
// - Pin-state levels follow the pins but hold under manual reset or software standby unless hardware standby is active; o_pin_level ignores the hold.
// - Under manual reset the alternate units let go, so pins follow direction and latch.
// - Pin functions are the same in every operating mode of the device.
// - Registers decode at index FEB1 direction, FF61 latch and FF51 pin levels.
// - Pin drive precedence is 8-bit timer, timer unit, then port or pulse output.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "port_two_defines.svh"
module port_two_top (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst_n,
   input  wire logic                     i_hw_standby,
   input  wire logic                     i_manual_rst,
   input  wire logic                     i_sw_standby,
   input  wire logic [`AVS_ADDR_W-1:0]   i_avs_address,
   input  wire logic                     i_avs_read,
   input  wire logic                     i_avs_write,
   input  wire logic [`AVS_DATA_W-1:0]   i_avs_writedata,
   input  wire logic [3:0]               i_avs_byteenable,
   output logic      [`AVS_DATA_W-1:0]   o_avs_readdata,
   output logic                          o_avs_waitrequest,
   input  wire port_two_pkg::port_byte_t i_pin_in,
   output port_two_pkg::port_byte_t      o_pin_out,
   output port_two_pkg::port_byte_t      o_pin_oe,
   output port_two_pkg::port_byte_t      o_pin_level,
   input  wire port_two_pkg::port_byte_t i_tmr_sel_nz,
   input  wire port_two_pkg::port_byte_t i_tmr_out,
   input  wire port_two_pkg::port_byte_t i_tpu_oe,
   input  wire port_two_pkg::port_byte_t i_tpu_out,
   input  wire port_two_pkg::port_byte_t i_ppg_en,
   input  wire port_two_pkg::port_byte_t i_ppg_out
);
   import port_two_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the pins and the standby pin

   port_byte_t pin_meta_ff;
   port_byte_t pin_sync_ff;
   logic       stby_meta_ff;
   logic       stby_sync_ff;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_meta_ff  <= `LEVELS_RESET;
         pin_sync_ff  <= `LEVELS_RESET;
         stby_meta_ff <= 1'b0;
         stby_sync_ff <= 1'b0;
      end else begin
         pin_meta_ff  <= i_pin_in;
         pin_sync_ff  <= pin_meta_ff;
         stby_meta_ff <= i_hw_standby;
         stby_sync_ff <= stby_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then waitrequest low for exactly one cycle

   bus_state_t                 state_ff;
   bus_state_t                 nxt_state_ff;
   logic                       waitreq_ff;
   logic                       nxt_waitreq_ff;
   logic [`AVS_DATA_W-1:0]     rdata_ff;
   logic [`AVS_DATA_W-1:0]     nxt_rdata_ff;
   logic [15:0]                reg_idx;
   logic                       hit_dir;
   logic                       hit_latch;
   logic                       hit_levels;
   logic                       wr_commit;
   logic                       frozen;
   port_byte_t                 pin_view;
   port_byte_t                 dir_ff;
   port_byte_t                 nxt_dir_ff;
   port_byte_t                 latch_ff;
   port_byte_t                 nxt_latch_ff;
   port_byte_t                 levels_ff;
   port_byte_t                 nxt_levels_ff;

   // Word index from the byte address
   assign reg_idx    = i_avs_address[`AVS_ADDR_W-1:`IDX_LSB];
   assign hit_dir    = (reg_idx == `DIR_IDX);
   assign hit_latch  = (reg_idx == `OUT_LATCH_IDX);
   assign hit_levels = (reg_idx == `PIN_LEVELS_IDX);
   // The CPU is halted in these states; a stray write must not disturb kept contents
   assign frozen     = stby_sync_ff || i_manual_rst || i_sw_standby;
   assign wr_commit  = i_avs_write && (state_ff == BUS_ACK) && !frozen
                       && i_avs_byteenable[`DATA_LANE];

   always_comb begin
      nxt_state_ff   = state_ff;
      nxt_waitreq_ff = 1'b1;
      nxt_rdata_ff   = rdata_ff;
      case (state_ff)
         BUS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               nxt_state_ff   = BUS_ACK;
               nxt_waitreq_ff = 1'b0;
               nxt_rdata_ff   = `UNMAPPED_READ;
               if (i_avs_read && hit_dir) begin
                  nxt_rdata_ff = {24'h00_0000, `DIR_READ_VALUE};
               end else if (i_avs_read && hit_latch) begin
                  nxt_rdata_ff = {24'h00_0000, latch_ff};
               end else if (i_avs_read && hit_levels) begin
                  nxt_rdata_ff = {24'h00_0000, pin_view};
               end
            end
         end
         BUS_ACK: begin
            nxt_state_ff = BUS_IDLE;
         end
         default: begin
            nxt_state_ff = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_ff   <= BUS_IDLE;
         waitreq_ff <= 1'b1;
         rdata_ff   <= `UNMAPPED_READ;
      end else begin
         state_ff   <= nxt_state_ff;
         waitreq_ff <= nxt_waitreq_ff;
         rdata_ff   <= nxt_rdata_ff;
      end
   end

   assign o_avs_waitrequest = waitreq_ff;
   assign o_avs_readdata    = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Direction, output latch and pin levels

   // Output pins read back their latch, input pins their sampled level
   assign pin_view = (dir_ff & latch_ff) | (~dir_ff & levels_ff);

   always_comb begin
      nxt_dir_ff    = dir_ff;
      nxt_latch_ff  = latch_ff;
      nxt_levels_ff = levels_ff;
      if (stby_sync_ff) begin
         nxt_dir_ff   = `DIR_RESET;
         nxt_latch_ff = `OUT_LATCH_RESET;
      end else if (wr_commit && hit_dir) begin
         nxt_dir_ff   = i_avs_writedata[7:0];
      end else if (wr_commit && hit_latch) begin
         nxt_latch_ff = i_avs_writedata[7:0];
      end
      // Writes to the pin-state register fall through and change nothing
      if (stby_sync_ff || !(i_manual_rst || i_sw_standby)) begin
         nxt_levels_ff = pin_sync_ff;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         dir_ff    <= `DIR_RESET;
         latch_ff  <= `OUT_LATCH_RESET;
         levels_ff <= `LEVELS_RESET;
      end else begin
         dir_ff    <= nxt_dir_ff;
         latch_ff  <= nxt_latch_ff;
         levels_ff <= nxt_levels_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin drive; no mode input exists, so every mode sees the same mapping

   pin_select_if u_sel_if ();

   assign u_sel_if.dir        = dir_ff;
   assign u_sel_if.latch      = latch_ff;
   assign u_sel_if.tmr_sel_nz = i_tmr_sel_nz;
   assign u_sel_if.tmr_out    = i_tmr_out;
   assign u_sel_if.tpu_oe     = i_tpu_oe;
   assign u_sel_if.tpu_out    = i_tpu_out;
   assign u_sel_if.ppg_en     = i_ppg_en;
   assign u_sel_if.ppg_out    = i_ppg_out;
   // Alternate units are held in reset with the manual reset
   assign u_sel_if.hold_alt   = i_manual_rst;

   port_two_pin_mux u_mux (
      .sel (u_sel_if.mux)
   );

   port_byte_t pin_out_ff;
   port_byte_t nxt_pin_out_ff;
   port_byte_t pin_oe_ff;
   port_byte_t nxt_pin_oe_ff;
   port_byte_t level_out_ff;
   port_byte_t nxt_level_out_ff;

   always_comb begin
      nxt_pin_out_ff   = u_sel_if.drv_out;
      nxt_pin_oe_ff    = u_sel_if.drv_oe;
      nxt_level_out_ff = pin_sync_ff;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_out_ff   <= 8'h00;
         pin_oe_ff    <= 8'h00;
         level_out_ff <= `LEVELS_RESET;
      end else begin
         pin_out_ff   <= nxt_pin_out_ff;
         pin_oe_ff    <= nxt_pin_oe_ff;
         level_out_ff <= nxt_level_out_ff;
      end
   end

   assign o_pin_out   = pin_out_ff;
   assign o_pin_oe    = pin_oe_ff;
   assign o_pin_level = level_out_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_dir_read_hidden: assert property (
      (state_ff == BUS_IDLE && i_avs_read && hit_dir) |=>
         !o_avs_waitrequest && o_avs_readdata[7:0] == `DIR_READ_VALUE)
      else $error("direction read did not return the filler value");

   a_dir_sets_oe: assert property (
      (i_tmr_sel_nz == 8'h00 && i_tpu_oe == 8'h00) |=> o_pin_oe == $past(dir_ff))
      else $error("pin enable does not follow the direction bits");

   a_reset_clears: assert property (disable iff (1'b0)
      !i_rst_n |=> dir_ff == `DIR_RESET && latch_ff == `OUT_LATCH_RESET)
      else $error("reset did not clear direction and latch");

   a_standby_clears: assert property (
      stby_sync_ff |=> dir_ff == `DIR_RESET && latch_ff == `OUT_LATCH_RESET)
      else $error("hardware standby did not clear direction and latch");

   a_manual_keeps: assert property (
      ((i_manual_rst || i_sw_standby) && !stby_sync_ff) |=> $stable(dir_ff) && $stable(latch_ff))
      else $error("direction or latch changed in manual reset or software standby");

   a_latch_write: assert property (
      (wr_commit && hit_latch) |=> latch_ff == $past(i_avs_writedata[7:0]))
      else $error("latch write not stored");

   a_levels_read_only: assert property (
      (i_avs_write && hit_levels) |=> $stable(latch_ff) && $stable(dir_ff))
      else $error("write to the pin-state register changed a register");

   a_read_out_bits: assert property (
      (state_ff == BUS_IDLE && i_avs_read && hit_levels) |=>
         (o_avs_readdata[7:0] & $past(dir_ff)) == ($past(latch_ff) & $past(dir_ff)))
      else $error("output pin read did not return latch bits");

   a_read_in_bits: assert property (
      (state_ff == BUS_IDLE && i_avs_read && hit_levels) |=>
         (o_avs_readdata[7:0] & ~$past(dir_ff)) == ($past(levels_ff) & ~$past(dir_ff)))
      else $error("input pin read did not return sampled levels");

   a_levels_hold: assert property (
      ((i_manual_rst || i_sw_standby) && !stby_sync_ff) |=> $stable(levels_ff))
      else $error("pin levels changed while they should hold");

   a_manual_plain: assert property (
      i_manual_rst |=> o_pin_oe == $past(dir_ff) && o_pin_out == $past(latch_ff))
      else $error("manual reset left an alternate unit on the pins");

   a_unmapped_zero: assert property (
      (state_ff == BUS_IDLE && i_avs_read && !hit_dir && !hit_latch && !hit_levels) |=>
         o_avs_readdata == `UNMAPPED_READ)
      else $error("unmapped read returned nonzero data");

   a_timer_first: assert property (
      !i_manual_rst |=> ((o_pin_out ^ $past(i_tmr_out)) & $past(i_tmr_sel_nz)) == 8'h00
         && (o_pin_oe & $past(i_tmr_sel_nz)) == $past(i_tmr_sel_nz))
      else $error("8-bit timer does not own its selected pins");

   a_bus_answers: assert property (
      (state_ff == BUS_IDLE && (i_avs_read || i_avs_write)) |=> !o_avs_waitrequest ##1
         o_avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");

endmodule

// >>> dv/pin_partner.sv
// Purpose: Far side of the port pins: external circuitry sharing each pin with the port
// Assumes: No pull resistors; the far side drives a pin whenever the port does not
// Notes:   Resolves the wire level fed back to the port's pin inputs
`timescale 1ns/1ns
module pin_partner (
   input  wire port_two_pkg::port_byte_t i_drv_out,
   input  wire port_two_pkg::port_byte_t i_drv_oe,
   input  wire port_two_pkg::port_byte_t i_ext,
   output port_two_pkg::port_byte_t      o_pin
);
   import port_two_pkg::*;

   // A released pin shows the far side's own level, never a stale port value
   always_comb begin
      o_pin = (i_drv_oe & i_drv_out) | (~i_drv_oe & i_ext);
   end
endmodule

// >>> dv/tb.sv
// Purpose: Self-checking bench for the eight-bit port two block
// Assumes: Avalon-MM master with waitrequest, pins resolved by pin_partner
// Notes:   Reads are scored by a monitor against a queue of expected words
`timescale 1ns/1ns
`include "port_two_defines.svh"
module tb;
   import port_two_pkg::*;

   logic                   i_clk_sys, i_rst_n, i_hw_standby, i_manual_rst, i_sw_standby;
   logic [`AVS_ADDR_W-1:0] i_avs_address;
   logic                   i_avs_read, i_avs_write;
   logic [`AVS_DATA_W-1:0] i_avs_writedata, o_avs_readdata;
   logic [3:0]             i_avs_byteenable;
   logic                   o_avs_waitrequest;
   port_byte_t             pin_wire, o_pin_out, o_pin_oe, o_pin_level, ext;
   port_byte_t             ts, tmo, to, tpo, pe, po, d, l, e;
   logic [31:0]            exp_q[$];
   logic [31:0]            seed;
   int                     n_fail, compares, cycles;

   port_two_top dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hw_standby(i_hw_standby),
      .i_manual_rst(i_manual_rst), .i_sw_standby(i_sw_standby),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_pin_in(pin_wire), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .o_pin_level(o_pin_level), .i_tmr_sel_nz(ts), .i_tmr_out(tmo), .i_tpu_oe(to),
      .i_tpu_out(tpo), .i_ppg_en(pe), .i_ppg_out(po)
   );

   pin_partner u_pins (
      .i_drv_out(o_pin_out), .i_drv_oe(o_pin_oe), .i_ext(ext), .o_pin(pin_wire)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction

   task automatic report_and_stop();
      $display("TB: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low; released only after that edge
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_address    <= {idx, 2'b00};
      i_avs_read       <= ~wr;
      i_avs_write      <= wr;
      i_avs_writedata  <= wd;
      i_avs_byteenable <= be;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, o_avs_waitrequest, 1'b0);
      end
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input port_byte_t v);
      bus(1'b1, idx, {24'h00_0000, v}, 4'h1);
   endtask

   task automatic rd(input logic [15:0] idx, input port_byte_t v);
      exp_q.push_back({24'h00_0000, v});
      bus(1'b0, idx, 32'h0000_0000, 4'hf);
   endtask

   task automatic pins(input port_byte_t exp_out, input port_byte_t exp_oe);
      repeat (3) @(posedge i_clk_sys);
      check({24'h00_0000, o_pin_out}, {24'h00_0000, exp_out});
      check({24'h00_0000, o_pin_oe}, {24'h00_0000, exp_oe});
   endtask

   task automatic alt(input logic [31:0] a, input logic [31:0] b);
      ts  <= a[7:0];
      tmo <= a[15:8];
      to  <= a[23:16];
      tpo <= a[31:24];
      pe  <= b[7:0];
      po  <= b[15:8];
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: every read answer takes the oldest expected word
   always @(posedge i_clk_sys) begin
      if (i_avs_read && o_avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, o_avs_readdata, 32'h0);
         end else begin
            check(o_avs_readdata, exp_q.pop_front());
         end
      end
   end

   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   initial begin
      {i_rst_n, i_hw_standby, i_manual_rst, i_sw_standby, i_avs_read, i_avs_write} = '0;
      i_avs_address = '0;
      i_avs_writedata = '0;
      i_avs_byteenable = '0;
      {ts, tmo, to, tpo, pe, po, ext} = '0;
      seed = 32'h0bcc;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(`OUT_LATCH_IDX, 8'h00);
      rd(`DIR_IDX, `DIR_READ_VALUE);
      rd(16'hff00, `UNMAPPED_READ);
      pins(8'h00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         {e, l, d} = seed[23:0];
         ext <= e;
         wr(`DIR_IDX, d);
         wr(`OUT_LATCH_IDX, l);
         wr(`PIN_LEVELS_IDX, ~l);
         bus(1'b1, `OUT_LATCH_IDX, {24'h0, ~l}, 4'h0);
         rd(`OUT_LATCH_IDX, l);
         rd(`PIN_LEVELS_IDX, (d & l) | (~d & e));
         pins(l, d);
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         alt(seed, lfsr(seed));
         @(posedge i_clk_sys);
         pins((ts & tmo) | (~ts & to & tpo) | (~ts & ~to & ((pe & po) | (~pe & l))),
              ts | to | d);
      end
      alt(32'h0, 32'h0);
      // Pins must pass the synchroniser before the level register freezes
      repeat (5) @(posedge i_clk_sys);
      i_manual_rst <= 1'b1;
      alt(32'hffff_ffff, 32'hffff_ffff);
      pins(l, d);
      ext <= ~e;
      wr(`OUT_LATCH_IDX, ~l);
      rd(`OUT_LATCH_IDX, l);
      rd(`PIN_LEVELS_IDX, (d & l) | (~d & e));
      i_manual_rst <= 1'b0;
      alt(32'h0, 32'h0);
      @(posedge i_clk_sys);
      i_sw_standby <= 1'b1;
      wr(`DIR_IDX, ~d);
      pins(l, d);
      i_sw_standby <= 1'b0;
      @(posedge i_clk_sys);
      i_hw_standby <= 1'b1;
      ext <= 8'h3c;
      repeat (3) @(posedge i_clk_sys);
      pins(8'h00, 8'h00);
      rd(`OUT_LATCH_IDX, 8'h00);
      rd(`PIN_LEVELS_IDX, 8'h3c);
      check({24'h00_0000, o_pin_level}, 32'h0000_003c);
      i_hw_standby <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      wr(`DIR_IDX, 8'hff);
      wr(`OUT_LATCH_IDX, 8'ha5);
      pins(8'ha5, 8'hff);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(`OUT_LATCH_IDX, 8'h00);
      pins(8'h00, 8'h00);
      repeat (2) @(posedge i_clk_sys);
      report_and_stop();
   end
endmodule
